// ---- hw/cie_defines.vh ----
// Offsets, field positions, encodings, reset values and timing counts of the execute block
`ifndef CIE_DEFINES_VH
`define CIE_DEFINES_VH

// Register byte offsets on the bus, one 32-bit word each
`define CIE_OFF_INSN      8'h00
`define CIE_OFF_ACC       8'h04
`define CIE_OFF_STATUS    8'h08
`define CIE_OFF_PC        8'h0C
`define CIE_OFF_BANK      8'h10
`define CIE_OFF_LATCH     8'h14
`define CIE_OFF_PTR0      8'h18
`define CIE_OFF_PTR1      8'h1C
`define CIE_OFF_FADDR     8'h20
`define CIE_OFF_FDATA     8'h24
`define CIE_OFF_STACK     8'h28
`define CIE_OFF_WDT       8'h2C
`define CIE_OFF_CTRL      8'h30

// Status register bit positions
`define CIE_ST_ZERO       0
`define CIE_ST_SLEEP      3
`define CIE_ST_EXPIRY     4
`define CIE_ST_UNKNOWN    7

// Control register bit positions
`define CIE_CTRL_WDT_EN   0

// Instruction word fields
`define CIE_OP_HI         13
`define CIE_OP_LO         10
`define CIE_D_BIT         7

// Major opcodes in bits 13:10; the literal branch uses bits 13:11
`define CIE_OP_MISC       4'h0
`define CIE_OP_COMPLEMENT_FILE       4'h1
`define CIE_OP_ZERO_FILE_REGISTER       4'h2
`define CIE_OP_DECREMENT_FILE       4'h3
`define CIE_OP_ACCUMULATOR_TO_FILE      4'h4
`define CIE_OP_IND        4'h5
`define CIE_OP_IND_REL    4'h6
`define CIE_OP_LIT_BANK   4'h7
`define CIE_OP_LIT_LATCH  4'h8
`define CIE_OP_LIT_ACC    4'h9
`define CIE_OP_CALL       3'h7

// Sub-operations of the misc group in bits 2:0
`define CIE_MISC_NOP      3'h0
`define CIE_MISC_WDT      3'h1
`define CIE_MISC_ZACC     3'h2
`define CIE_MISC_SUBROUTINE_BRANCH_ACCUMULATOR    3'h3

// Pointer update codes
`define CIE_MM_PREINC     2'h0
`define CIE_MM_PREDEC     2'h1
`define CIE_MM_POSTINC    2'h2
`define CIE_MM_POSTDEC    2'h3

// Indirect window file addresses
`define CIE_WIN0          7'h00
`define CIE_WIN1          7'h01

// Reset values
`define CIE_RST_PC        15'h0000
`define CIE_RST_PTR       16'h0000
`define CIE_RST_FLAG_HI   1'b1

// Watchdog timing counts
`define CIE_WDT_PRE_MAX   8'hFF
`define CIE_WDT_CNT_MAX   16'hFFFF

// Return stack depth
`define CIE_STACK_DEPTH   16

`endif

// ---- hw/cie_return_stack.v ----
// Return address stack for the execute block
`timescale 1ns/1ps
`default_nettype none

`include "cie_defines.vh"

module cie_return_stack (
    input  wire        i_mclk,
    input  wire        i_rst,
    input  wire        i_push,
    input  wire [14:0] i_push_addr,
    output reg  [14:0] o_top,
    output reg  [4:0]  o_depth
);

    reg [14:0] stack_mem [0:`CIE_STACK_DEPTH-1];
    reg [3:0]  sp;

    // Push stores the address and wraps when full; depth saturates
    always @(posedge i_mclk) begin
        if (i_rst) begin
            sp      <= 4'h0;
            o_top   <= 15'h0000;
            o_depth <= 5'h00;
        end else if (i_push) begin
            stack_mem[sp] <= i_push_addr;
            sp            <= sp + 4'h1;
            o_top         <= i_push_addr;
            if (o_depth != 5'h10) begin
                o_depth <= o_depth + 5'h01;
            end
        end
    end

endmodule

`default_nettype wire

// ---- hw/cie_core_instruction_execute.v ----
// Instruction execute block with its Avalon-MM register slave
//
// Notes on behaviour
// - Literal branch pushes counter plus one, loads literal and upper latch bits 6:3.
// - Literal branch takes two cycles and leaves every status flag alone.
// - Accumulator branch pushes return, loads accumulator low, latch high; two cycles.
// - Watchdog restart clears counter and prescaler, sets expiry and sleep flags.
// - Complement inverts file byte into accumulator or file; updates zero flag.
// - File clear writes zero and always sets the zero flag.
// - Decrement subtracts one into accumulator or file; updates zero flag.
// - Accumulator clear loads zero and always sets the zero flag.
// - Indirect load mode code picks pre/post increment or decrement of pointer.
// - Relative indirect load uses pointer plus signed offset, pointer unchanged.
// - Window addresses access the register the matching pointer holds.
// - Pointers are 16 bits and wrap at both ends.
// - Bank literal load stores five bits, flags unchanged.
// - Upper latch literal load stores seven bits, flags unchanged.
// - Accumulator literal load stores eight bits in one cycle, flags unchanged.
// - Accumulator to file move copies in one cycle, flags unchanged.
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

`include "cie_defines.vh"

module cie_core_instruction_execute (
    input  wire        i_mclk,
    input  wire        i_rst,
    input  wire [7:0]  i_address,
    input  wire        i_read,
    input  wire        i_write,
    input  wire [31:0] i_writedata,
    input  wire [3:0]  i_byteenable,
    output reg  [31:0] o_readdata,
    output reg         o_waitrequest,
    output reg  [14:0] o_pc
);

    localparam ST_IDLE = 1'b0;
    localparam ST_BR2  = 1'b1;

    // Architectural state
    reg [7:0]  acc;
    reg [4:0]  bank;
    reg [6:0]  latch;
    reg [15:0] ptr0;
    reg [15:0] ptr1;
    reg        zero_flag;
    reg        expiry_flag;
    reg        sleep_flag;
    reg        unknown_flag;
    reg        wdt_en;
    reg [7:0]  wdt_pre;
    reg [15:0] wdt_cnt;
    reg [7:0]  faddr;
    reg        state;
    reg [7:0]  data_mem [0:255];
    // Combinational results
    reg [7:0]  next_acc;
    reg        next_zero;
    reg [4:0]  next_bank;
    reg [6:0]  next_latch;
    reg [15:0] next_ptr0;
    reg [15:0] next_ptr1;
    reg [14:0] next_pc;
    reg        next_unknown;
    reg        mem_we;
    reg [7:0]  mem_addr;
    reg [7:0]  mem_wdata;
    reg        push;
    reg        two_cycle;
    reg        wdt_restart;
    reg [31:0] next_rdata;
    reg [15:0] sel_ptr;
    reg [15:0] new_ptr;
    reg [15:0] eff_addr;
    reg [7:0]  file_val;
    reg [7:0]  result;
    reg [31:0] merged;
    wire [14:0] stack_top;
    wire [4:0]  stack_depth;
    wire        req;
    wire        take;
    wire        exec_go;
    wire [13:0] insn;
    wire [3:0]  opcode;
    wire [6:0]  f_field;
    wire        d_bit;
    // Resolve a file address; window locations follow their pointer
    function [7:0] cie_file_addr;
        input [6:0]  f;
        input [4:0]  b;
        input [15:0] p0;
        input [15:0] p1;
        begin
            cie_file_addr = (f == `CIE_WIN0) ? p0[7:0] :
                            (f == `CIE_WIN1) ? p1[7:0] : {b[0], f};
        end
    endfunction
    // Merge written bytes into an old register value by byte enables
    function [31:0] cie_be_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        integer k;
        begin
            cie_be_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    cie_be_merge[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
        end
    endfunction
    // Zero test shared by the flag-updating operations
    function cie_is_zero;
        input [7:0] v;
        begin
            cie_is_zero = (v == 8'h00);
        end
    endfunction
    // Request decode and instruction fields
    assign req     = i_read | i_write;
    assign take    = req & o_waitrequest & (state == ST_IDLE);
    assign exec_go = take & i_write & (i_address == `CIE_OFF_INSN);
    assign insn    = i_writedata[13:0];
    assign opcode  = insn[`CIE_OP_HI:`CIE_OP_LO];
    assign f_field = insn[6:0];
    assign d_bit   = insn[`CIE_D_BIT];
    // Return stack, pushed with the address after the branch
    cie_return_stack u_stack (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_push      (push),
        .i_push_addr (o_pc + 15'h0001),
        .o_top       (stack_top),
        .o_depth     (stack_depth)
    );
    // Instruction decode and execute, plus bus writes to state
    always @* begin
        next_acc     = acc;
        next_zero    = zero_flag;
        next_bank    = bank;
        next_latch   = latch;
        next_ptr0    = ptr0;
        next_ptr1    = ptr1;
        next_pc      = o_pc;
        next_unknown = unknown_flag;
        mem_we       = 1'b0;
        mem_addr     = cie_file_addr(f_field, bank, ptr0, ptr1);
        mem_wdata    = 8'h00;
        push         = 1'b0;
        two_cycle    = 1'b0;
        wdt_restart  = 1'b0;
        sel_ptr      = insn[2] ? ptr1 : ptr0;
        new_ptr      = sel_ptr;
        eff_addr     = sel_ptr;
        file_val     = data_mem[mem_addr];
        result       = 8'h00;
        merged       = 32'h0000_0000;
        if (exec_go) begin
            next_pc = o_pc + 15'h0001;
            if (insn[13:11] == `CIE_OP_CALL) begin
                push      = 1'b1;
                next_pc   = {latch[6:3], insn[10:0]};
                two_cycle = 1'b1;
            end else begin
                case (opcode)
                    `CIE_OP_MISC: begin
                        case (insn[2:0])
                            `CIE_MISC_NOP: next_unknown = unknown_flag;
                            `CIE_MISC_WDT: wdt_restart = 1'b1;
                            `CIE_MISC_ZACC: begin
                                next_acc  = 8'h00;
                                next_zero = 1'b1;
                            end
                            `CIE_MISC_SUBROUTINE_BRANCH_ACCUMULATOR: begin
                                push      = 1'b1;
                                next_pc   = {latch, acc};
                                two_cycle = 1'b1;
                            end
                            default: next_unknown = 1'b1;
                        endcase
                    end
                    `CIE_OP_COMPLEMENT_FILE: begin
                        result    = ~file_val;
                        next_zero = cie_is_zero(result);
                        mem_we    = d_bit;
                        mem_wdata = result;
                        if (!d_bit) begin
                            next_acc = result;
                        end
                    end
                    `CIE_OP_ZERO_FILE_REGISTER: begin
                        mem_we    = 1'b1; // Write data defaults to zero
                        next_zero = 1'b1;
                    end
                    `CIE_OP_DECREMENT_FILE: begin
                        result    = file_val - 8'h01;
                        next_zero = cie_is_zero(result);
                        mem_we    = d_bit;
                        mem_wdata = result;
                        if (!d_bit) begin
                            next_acc = result;
                        end
                    end
                    `CIE_OP_ACCUMULATOR_TO_FILE: begin
                        mem_we    = 1'b1;
                        mem_wdata = acc;
                    end
                    `CIE_OP_IND: begin
                        new_ptr   = insn[0] ? sel_ptr - 16'h0001 : sel_ptr + 16'h0001;
                        eff_addr  = insn[1] ? sel_ptr : new_ptr; // Post modes use old pointer
                        result    = data_mem[eff_addr[7:0]];
                        next_acc  = result;
                        next_zero = cie_is_zero(result);
                        next_ptr0 = insn[2] ? ptr0 : new_ptr;
                        next_ptr1 = insn[2] ? new_ptr : ptr1;
                    end
                    `CIE_OP_IND_REL: begin
                        sel_ptr   = insn[6] ? ptr1 : ptr0;
                        eff_addr  = sel_ptr + {{10{insn[5]}}, insn[5:0]};
                        result    = data_mem[eff_addr[7:0]];
                        next_acc  = result;
                        next_zero = cie_is_zero(result);
                    end
                    `CIE_OP_LIT_BANK: next_bank = insn[4:0];
                    `CIE_OP_LIT_LATCH: next_latch = insn[6:0];
                    `CIE_OP_LIT_ACC: next_acc = insn[7:0];
                    default: next_unknown = 1'b1;
                endcase
            end
        end else if (take & i_write) begin
            case (i_address)
                `CIE_OFF_ACC: begin
                    merged   = cie_be_merge({24'h00_0000, acc}, i_writedata, i_byteenable);
                    next_acc = merged[7:0];
                end
                `CIE_OFF_BANK: begin
                    merged    = cie_be_merge({27'h000_0000, bank}, i_writedata, i_byteenable);
                    next_bank = merged[4:0];
                end
                `CIE_OFF_LATCH: begin
                    merged     = cie_be_merge({25'h000_0000, latch}, i_writedata, i_byteenable);
                    next_latch = merged[6:0];
                end
                `CIE_OFF_PTR0: begin
                    merged    = cie_be_merge({16'h0000, ptr0}, i_writedata, i_byteenable);
                    next_ptr0 = merged[15:0];
                end
                `CIE_OFF_PTR1: begin
                    merged    = cie_be_merge({16'h0000, ptr1}, i_writedata, i_byteenable);
                    next_ptr1 = merged[15:0];
                end
                `CIE_OFF_FDATA: begin
                    mem_addr  = faddr;
                    mem_we    = i_byteenable[0];
                    mem_wdata = i_writedata[7:0];
                end
                default: next_unknown = unknown_flag;
            endcase
        end
    end

    // Read data selection
    always @* begin
        case (i_address)
            `CIE_OFF_ACC:    next_rdata = {24'h00_0000, acc};
            `CIE_OFF_STATUS: next_rdata = {24'h00_0000, unknown_flag, 2'b00, expiry_flag,
                                           sleep_flag, 2'b00, zero_flag};
            `CIE_OFF_PC:     next_rdata = {17'h0_0000, o_pc};
            `CIE_OFF_BANK:   next_rdata = {27'h000_0000, bank};
            `CIE_OFF_LATCH:  next_rdata = {25'h000_0000, latch};
            `CIE_OFF_PTR0:   next_rdata = {16'h0000, ptr0};
            `CIE_OFF_PTR1:   next_rdata = {16'h0000, ptr1};
            `CIE_OFF_FADDR:  next_rdata = {24'h00_0000, faddr};
            `CIE_OFF_FDATA:  next_rdata = {24'h00_0000, data_mem[faddr]};
            `CIE_OFF_STACK:  next_rdata = {11'h000, stack_depth, 1'b0, stack_top};
            `CIE_OFF_WDT:    next_rdata = {8'h00, wdt_pre, wdt_cnt};
            `CIE_OFF_CTRL:   next_rdata = {31'h0000_0000, wdt_en};
            default:         next_rdata = 32'h0000_0000;
        endcase
    end

    // Data memory write port
    always @(posedge i_mclk) begin
        if (mem_we) begin
            data_mem[mem_addr] <= mem_wdata;
        end
    end

    // Bus handshake, sequencing and architectural registers
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_waitrequest <= 1'b1;
            o_readdata    <= 32'h0000_0000;
            o_pc          <= `CIE_RST_PC;
            state         <= ST_IDLE;
            acc           <= 8'h00;
            bank          <= 5'h00;
            latch         <= 7'h00;
            ptr0          <= `CIE_RST_PTR;
            ptr1          <= `CIE_RST_PTR;
            zero_flag     <= 1'b0;
            unknown_flag  <= 1'b0;
            faddr         <= 8'h00;
            wdt_en        <= 1'b0;
        end else begin
            o_waitrequest <= 1'b1;
            acc           <= next_acc;
            bank          <= next_bank;
            latch         <= next_latch;
            ptr0          <= next_ptr0;
            ptr1          <= next_ptr1;
            zero_flag     <= next_zero;
            unknown_flag  <= next_unknown;
            o_pc          <= next_pc;
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        o_readdata <= i_read ? next_rdata : 32'h0000_0000;
                        if (two_cycle) begin
                            state <= ST_BR2;
                        end else begin
                            o_waitrequest <= 1'b0;
                        end
                        if (i_write && (i_address == `CIE_OFF_FADDR) && i_byteenable[0]) begin
                            faddr <= i_writedata[7:0];
                        end
                        if (i_write && (i_address == `CIE_OFF_CTRL) && i_byteenable[0]) begin
                            wdt_en <= i_writedata[`CIE_CTRL_WDT_EN];
                        end
                    end
                end
                ST_BR2: begin
                    state         <= ST_IDLE;
                    o_waitrequest <= 1'b0;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Watchdog prescaler, counter and its two flags
    always @(posedge i_mclk) begin
        if (i_rst) begin
            wdt_pre     <= 8'h00;
            wdt_cnt     <= 16'h0000;
            expiry_flag <= `CIE_RST_FLAG_HI;
            sleep_flag  <= `CIE_RST_FLAG_HI;
        end else if (wdt_restart) begin
            wdt_pre     <= 8'h00;
            wdt_cnt     <= 16'h0000;
            expiry_flag <= 1'b1;
            sleep_flag  <= 1'b1;
        end else if (wdt_en) begin
            wdt_pre <= wdt_pre + 8'h01;
            if (wdt_pre == `CIE_WDT_PRE_MAX) begin
                wdt_cnt <= wdt_cnt + 16'h0001;
                if (wdt_cnt == `CIE_WDT_CNT_MAX) begin
                    expiry_flag <= 1'b0;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ---- sim/cie_prog_mem.sv ----
// Program memory model feeding instruction words for the branch scenario
`timescale 1ns/1ps
`default_nettype none
module cie_prog_mem (
    input  wire logic [14:0] i_pc,
    output logic      [13:0] o_word
);
    // Short fixed program, indexed by the low counter bits
    always_comb begin
        case (i_pc[4:0])
            5'h00: o_word = 14'h2028; // Upper latch 0x28
            5'h01: o_word = 14'h3923; // Literal branch to 0x123
            5'h03: o_word = 14'h2012; // Upper latch 0x12
            5'h04: o_word = 14'h2434; // Accumulator 0x34
            5'h05: o_word = 14'h0003; // Accumulator branch
            default: o_word = 14'h0000; // No operation
        endcase
    end
endmodule
`default_nettype wire

// ---- sim/cie_core_instruction_execute_checker.sv ----
// Port-level assertions for the execute block
`timescale 1ns/1ps
`default_nettype none
module cie_core_instruction_execute_checker (
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_address,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0]  i_byteenable,
    input wire logic [31:0] o_readdata,
    input wire logic        o_waitrequest,
    input wire logic [14:0] o_pc
);
    logic            busy;
    wire logic       take = (i_read | i_write) & o_waitrequest & ~busy;
    wire logic       ins  = take & i_write & (i_address == 8'h00);
    wire logic [3:0] op   = i_writedata[13:10];
    // Marks a request taken but not yet answered
    always @(posedge i_mclk) begin
        if (i_rst)
            busy <= 1'b0;
        else if (take)
            busy <= 1'b1;
        else if (!o_waitrequest)
            busy <= 1'b0;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_call_pc;
        ins && op[3:1] == 3'h7 |=> o_pc[10:0] == $past(i_writedata[10:0]);
    endproperty
    a_call_pc: assert property (p_call_pc) else $error("branch target wrong");
    property p_call_len;
        ins && op[3:1] == 3'h7 |=> o_waitrequest ##1 !o_waitrequest;
    endproperty
    a_call_len: assert property (p_call_len) else $error("branch length wrong");
    property p_subroutine_branch_accumulator_len;
        ins && i_writedata[13:0] == 14'h0003 |=> o_waitrequest ##1 !o_waitrequest;
    endproperty
    a_subroutine_branch_accumulator_len: assert property (p_subroutine_branch_accumulator_len) else $error("acc branch length wrong");
    property p_literal_to_accumulator;
        ins && op == 4'h9 |=> !o_waitrequest && o_pc == $past(o_pc) + 15'h0001;
    endproperty
    a_literal_to_accumulator: assert property (p_literal_to_accumulator) else $error("literal load not one cycle");
    property p_accumulator_to_file;
        ins && op == 4'h4 |=> !o_waitrequest ##1 o_waitrequest;
    endproperty
    a_accumulator_to_file: assert property (p_accumulator_to_file) else $error("file move not one cycle");
    property p_wdt;
        ins && i_writedata[13:0] == 14'h0001 |=> !o_waitrequest;
    endproperty
    a_wdt: assert property (p_wdt) else $error("restart not one cycle");
    property p_pc_hold;
        !take |=> $stable(o_pc);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("counter moved idle");
    property p_read_pc;
        take && i_read && i_address == 8'h0C |=> o_readdata == {17'h0_0000, $past(o_pc)};
    endproperty
    a_read_pc: assert property (p_read_pc) else $error("counter readback wrong");
endmodule
bind cie_core_instruction_execute cie_core_instruction_execute_checker u_chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_pc(o_pc));
`default_nettype wire

// ---- sim/test_core_instruction_execute.sv ----
// Self-checking bench for the execute block
`timescale 1ns/1ps
`default_nettype none
module test_core_instruction_execute;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_address = 8'h00;
    logic        i_read = 1'b0;
    logic        i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0000_0000;
    logic [31:0] o_readdata;
    logic        o_waitrequest;
    logic [14:0] o_pc;
    logic [13:0] pm_word;
    logic [31:0] q;
    integer      n_mismatch = 0;
    integer      tests_run = 0;
    integer      cyc = 0;

    cie_core_instruction_execute uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_pc(o_pc));
    cie_prog_mem pm (.i_pc(o_pc), .o_word(pm_word));

    // Clock
    initial begin
        forever #2 i_mclk = ~i_mclk;
    end
    // Hang guard
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end

    task close_out;
        begin
            $display("compares %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] want);
        begin
            tests_run = tests_run + 1;
            if (got !== want) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD t=%0t got=%h want=%h", $time, got, want);
            end
        end
    endtask
    // One transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge i_mclk);
            i_address <= a;
            i_write <= wr;
            i_read <= ~wr;
            i_writedata <= d;
            @(posedge i_mclk);
            while (o_waitrequest !== 1'b0)
                @(posedge i_mclk);
            q = o_readdata;
            i_write <= 1'b0;
            i_read <= 1'b0;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task ex(input logic [13:0] w);
        bus(1'b1, 8'h00, {18'h0_0000, w});
    endtask
    task rc(input logic [7:0] a, input logic [31:0] want);
        begin
            bus(1'b0, a, 32'h0000_0000);
            chk(q, want);
        end
    endtask

    // Branches fetched from program memory
    task t_branch;
        begin
            ex(pm_word);
            ex(pm_word);
            chk(o_pc, 15'h2923);
            rc(8'h28, 32'h0001_0002);
            ex(pm_word);
            ex(pm_word);
            ex(pm_word);
            chk(o_pc, 15'h1234);
            rc(8'h28, 32'h0002_2926);
            rc(8'h08, 8'h18);
        end
    endtask
    // Literal loads and accumulator clear
    task t_lit;
        begin
            ex(14'h245A);
            rc(8'h04, 8'h5A);
            ex(14'h1C1F);
            rc(8'h10, 8'h1F);
            ex(14'h207F);
            rc(8'h14, 8'h7F);
            rc(8'h08, 8'h18);
            ex(14'h0002);
            rc(8'h04, 8'h00);
            rc(8'h08, 8'h19);
            rc(8'h0C, 32'h1238);
        end
    endtask
    // File operations, bank 0x1F (bit 0 set) so direct address is 0x90
    task t_file;
        begin
            wr(8'h20, 8'h90);
            wr(8'h24, 8'h01);
            ex(14'h0490);
            rc(8'h24, 8'hFE);
            rc(8'h08, 8'h18);
            ex(14'h0410);
            rc(8'h04, 8'h01);
            ex(14'h0C10);
            rc(8'h04, 8'hFD);
            wr(8'h24, 8'h01);
            ex(14'h0C90);
            rc(8'h24, 8'h00);
            rc(8'h08, 8'h19);
            ex(14'h1010);
            rc(8'h24, 8'hFD);
            ex(14'h0410);
            ex(14'h0810);
            rc(8'h24, 8'h00);
            rc(8'h08, 8'h19);
        end
    endtask
    // Indirect loads in every update mode, relative form and window
    task t_ind;
        begin
            wr(8'h20, 8'h00);
            wr(8'h24, 8'h33);
            wr(8'h20, 8'hFE);
            wr(8'h24, 8'h00);
            wr(8'h18, 16'hFFFF);
            ex(14'h1400);
            rc(8'h04, 8'h33);
            rc(8'h18, 16'h0000);
            ex(14'h1403);
            rc(8'h18, 16'hFFFF);
            ex(14'h1401);
            rc(8'h18, 16'hFFFE);
            rc(8'h08, 8'h19);
            ex(14'h1402);
            rc(8'h18, 16'hFFFF);
            wr(8'h1C, 8'h40);
            wr(8'h20, 8'h20);
            wr(8'h24, 8'h77);
            ex(14'h1860);
            rc(8'h04, 8'h77);
            rc(8'h1C, 8'h40);
            rc(8'h08, 8'h18);
            ex(14'h1001);
            wr(8'h20, 8'h40);
            rc(8'h24, 8'h77);
        end
    endtask
    // Watchdog restart with a frozen nonzero prescaler
    task t_wdt;
        begin
            wr(8'h30, 8'h01);
            wr(8'h30, 8'h00);
            rc(8'h2C, 32'h0003_0000);
            ex(14'h0001);
            rc(8'h2C, 32'h0000_0000);
            rc(8'h08, 8'h18);
        end
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_branch();
        t_lit();
        t_file();
        t_ind();
        t_wdt();
        close_out();
    end
endmodule
`default_nettype wire
